// ===== dv/mpc_periph_bank_asserts.sv
// port assertions for the peripheral control bank
`timescale 1ns/1ns
`default_nettype none
`include "mpc_defs.svh"
module mpc_periph_bank_asserts (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  clk_en,
  input wire mpc_pkg::mpc_bus_req_s bus_req,
  input wire logic [7:0]            bus_rdata,
  input wire mpc_pkg::mpc_core_s    core_in,
  input wire logic                  conv_start,
  input wire logic                  ctrl_segment_sel,
  input wire logic                  global_irq_enable,
  input wire logic [6:0]            irq_pending,
  input wire logic [7:0]            port_a_direction,
  input wire logic [2:0]            amp1_gain,
  input wire logic [2:0]            amp2_gain
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic rd_go;
  logic wr_go;
  assign rd_go = bus_req.rd && clk_en;
  assign wr_go = bus_req.wr && clk_en;
  AST_STATUS_MASKED: assert property (rd_go && bus_req.addr == `MPC_OFF_IRQ_STATUS
    |=> bus_rdata == {1'b0, $past(irq_pending)}) else $error("status read not masked");
  AST_CONV_TOP_ZERO: assert property (rd_go && bus_req.addr == `MPC_OFF_CONV_CTRL
    |=> bus_rdata[7:6] == 2'b00) else $error("converter control top bits not zero");
  AST_START_CAUSE: assert property (conv_start
    |-> wr_go && bus_req.addr == `MPC_OFF_CONV_CTRL && bus_req.wdata[4])
    else $error("start pulse without run write");
  AST_SEG_WRITE: assert property (wr_go && bus_req.addr == `MPC_OFF_CONV_CTRL
    |=> ctrl_segment_sel == $past(bus_req.wdata[5])) else $error("segment select wrong");
  AST_DIR_WRITE: assert property (wr_go && bus_req.addr == `MPC_OFF_PORT_A_DIR
    |=> port_a_direction == $past(bus_req.wdata)) else $error("direction write lost");
  AST_GAIN_CLAMP: assert property (amp1_gain <= 3'h5 && amp2_gain <= 3'h5)
    else $error("gain above highest code");
  AST_GIE_OFF: assert property (clk_en && (core_in.disable_irq_instr || core_in.irq_entry)
    |=> !global_irq_enable) else $error("global enable not cleared");
  AST_GIE_ON: assert property (clk_en && !core_in.disable_irq_instr && !core_in.irq_entry
    && (core_in.enable_irq_instr || core_in.return_from_irq_instr) |=> global_irq_enable)
    else $error("global enable not set");
  AST_FLAG_HOLD: assert property (|($past(irq_pending) & ~irq_pending)
    |-> $past(wr_go) && ($past(bus_req.addr) inside {`MPC_OFF_IRQ_STATUS, `MPC_OFF_IRQ_MASK}))
    else $error("flag dropped without write");
endmodule
bind mpc_periph_bank mpc_periph_bank_asserts u_chk (.clk(clk), .reset(reset), .clk_en(clk_en),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .core_in(core_in), .conv_start(conv_start),
  .ctrl_segment_sel(ctrl_segment_sel), .global_irq_enable(global_irq_enable),
  .irq_pending(irq_pending), .port_a_direction(port_a_direction), .amp1_gain(amp1_gain),
  .amp2_gain(amp2_gain));
`default_nettype wire

// ===== dv/mpc_periph_bank_test.sv
// self-checking bench for the peripheral control bank
`timescale 1ns/1ns
`default_nettype none
`include "mpc_defs.svh"
module mpc_periph_bank_test;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  clk_en = 1'b1;
  logic                  conv_done_in = 1'b0;
  logic [7:0]            conv_data_in = 8'h00;
  mpc_pkg::mpc_bus_req_s bus_req = '0;
  mpc_pkg::mpc_evt_s     evt_in = '0;
  mpc_pkg::mpc_evt_s     ev_r = '0;
  mpc_pkg::mpc_core_s    core_in = '0;
  logic [7:0]            bus_rdata, port_a_direction, port_b_direction;
  logic                  conv_start, conv_power_on, ctrl_segment_sel, global_irq_enable;
  logic                  amp1_on, amp2_on, wdt_tick;
  logic [2:0]            channel_sel, amp1_gain, amp2_gain;
  logic [6:0]            irq_pending;
  int                    n_fail = 0;
  int                    total_checks = 0;
  int                    wdt_n = 0;
  int                    n_start = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (wdt_tick === 1'b1) wdt_n <= wdt_n + 1;
  always @(posedge clk) if (conv_start === 1'b1) n_start <= n_start + 1;
  mpc_periph_bank i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .evt_in(evt_in), .core_in(core_in), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .conv_start(conv_start), .conv_power_on(conv_power_on),
    .channel_sel(channel_sel), .ctrl_segment_sel(ctrl_segment_sel),
    .global_irq_enable(global_irq_enable), .irq_pending(irq_pending),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .amp1_on(amp1_on), .amp2_on(amp2_on), .amp1_gain(amp1_gain), .amp2_gain(amp2_gain),
    .wdt_tick(wdt_tick));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 check(what, bus_rdata, exp);
  endtask
  // pulse fields of ev_r last one cycle, levels stay
  task automatic step;
    @(posedge clk);
    evt_in <= ev_r;
    @(posedge clk);
    {ev_r.pulse1_hit, ev_r.pulse2_hit, ev_r.instr_tick, ev_r.wdt_osc_tick} = 4'h0;
    evt_in <= ev_r;
  endtask
  task automatic t_regs;
    rchk("dir a rst", `MPC_OFF_PORT_A_DIR, 8'hFF);
    check("dir a pins", port_a_direction, 8'hFF);
    rchk("gain rst", `MPC_OFF_AMP_GAIN, 8'h00);
    wr(`MPC_OFF_PORT_B_DIR, 8'hA5);
    rchk("dir b", `MPC_OFF_PORT_B_DIR, 8'hA5);
    check("dir b pins", port_b_direction, 8'hA5);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(`MPC_OFF_PORT_B_DIR, 8'h3C);
    clk_en <= 1'b1;
    rchk("dir b frozen", `MPC_OFF_PORT_B_DIR, 8'hA5);
    wr(`MPC_OFF_AMP_GAIN, 8'hFE);
    rchk("gain undef", `MPC_OFF_AMP_GAIN, 8'hFE);
    check("gains", {amp2_on, amp1_on, amp2_gain, amp1_gain}, 8'hED);
    wr(`MPC_OFF_AMP_GAIN, 8'h1C);
    #1 check("gains off", {amp2_on, amp1_on, amp2_gain, amp1_gain}, 8'h1C);
    $display("register test finished");
  endtask
  task automatic t_ctrl;
    wr(`MPC_OFF_CONV_CTRL, 8'hEF);
    rchk("conv ctrl", `MPC_OFF_CONV_CTRL, 8'h2F);
    check("seg", ctrl_segment_sel, 8'h01);
    check("power", conv_power_on, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      wr(`MPC_OFF_CONV_CTRL, 8'h00 | c[2:0]);
      #1 check("channel", channel_sel, c[2:0]);
      check("seg off", ctrl_segment_sel, 8'h00);
    end
    check("power off", conv_power_on, 8'h00);
    $display("control test finished");
  endtask
  task automatic t_conv;
    wr(`MPC_OFF_IRQ_MASK, 8'hFF);
    wr(`MPC_OFF_CONV_CTRL, 8'h1A);
    wr(`MPC_OFF_CONV_CTRL, 8'h1D);
    rchk("run held", `MPC_OFF_CONV_CTRL, 8'h1A);
    check("starts", n_start[7:0], 8'h01);
    @(posedge clk);
    conv_done_in <= 1'b1;
    conv_data_in <= 8'hA5;
    @(posedge clk);
    conv_done_in <= 1'b0;
    rchk("result", `MPC_OFF_CONV_RESULT, 8'hA5);
    rchk("run clear", `MPC_OFF_CONV_CTRL, 8'h0A);
    rchk("done flag", `MPC_OFF_IRQ_STATUS, 8'h08);
    wr(`MPC_OFF_CONV_CTRL, 8'h0D);
    rchk("ch locked", `MPC_OFF_CONV_CTRL, 8'h0A);
    wr(`MPC_OFF_IRQ_STATUS, 8'h00);
    wr(`MPC_OFF_CONV_CTRL, 8'h0D);
    rchk("ch free", `MPC_OFF_CONV_CTRL, 8'h0D);
    $display("conversion test finished");
  endtask
  task automatic t_flags;
    ev_r.cmp_out = 1'b1;
    ev_r.pulse1_hit = 1'b1;
    ev_r.pulse2_hit = 1'b1;
    ev_r.port_b_in = 8'h01;
    ev_r.ext_pin = 1'b1;
    step;
    rchk("events", `MPC_OFF_IRQ_STATUS, 8'h76);
    wr(`MPC_OFF_IRQ_STATUS, 8'hFF);
    rchk("no set", `MPC_OFF_IRQ_STATUS, 8'h76);
    wr(`MPC_OFF_IRQ_STATUS, 8'hEF);
    wr(`MPC_OFF_IRQ_MASK, 8'h0F);
    rchk("masked", `MPC_OFF_IRQ_STATUS, 8'h06);
    check("pending", {1'b0, irq_pending}, 8'h06);
    wr(`MPC_OFF_IRQ_MASK, 8'hFF);
    rchk("cleared", `MPC_OFF_IRQ_STATUS, 8'h66);
    @(posedge clk);
    bus_req <= '{addr: `MPC_OFF_IRQ_STATUS, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
    evt_in.pulse1_hit <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    evt_in.pulse1_hit <= 1'b0;
    rchk("set wins", `MPC_OFF_IRQ_STATUS, 8'h10);
    wr(`MPC_OFF_IRQ_STATUS, 8'h00);
    ev_r.ext_pin = 1'b0;
    step;
    rchk("fall ignored", `MPC_OFF_IRQ_STATUS, 8'h00);
    wr(`MPC_OFF_TIMER_CTRL, 8'h80);
    ev_r.ext_pin = 1'b1;
    step;
    ev_r.ext_pin = 1'b0;
    step;
    rchk("fall edge", `MPC_OFF_IRQ_STATUS, 8'h04);
    $display("flag test finished");
  endtask
  task automatic t_timer;
    wr(`MPC_OFF_TIMER_CTRL, 8'h08);
    wr(`MPC_OFF_IRQ_STATUS, 8'h00);
    wr(`MPC_OFF_TIMER, 8'hFF);
    ev_r.instr_tick = 1'b1;
    step;
    rchk("wrap", `MPC_OFF_TIMER, 8'h00);
    rchk("ovf", `MPC_OFF_IRQ_STATUS, 8'h01);
    wr(`MPC_OFF_TIMER_CTRL, 8'h01);
    wr(`MPC_OFF_TIMER, 8'h00);
    repeat (8)
    begin
      ev_r.instr_tick = 1'b1;
      step;
    end
    rchk("div4", `MPC_OFF_TIMER, 8'h02);
    for (int e = 0; e < 2; e++)
    begin
      wr(`MPC_OFF_TIMER_CTRL, e ? 8'h38 : 8'h28);
      wr(`MPC_OFF_TIMER, 8'h00);
      ev_r.timer_pin = 1'b1;
      ev_r.instr_tick = 1'b1;
      step;
      rchk("pin first", `MPC_OFF_TIMER, e ? 8'h00 : 8'h01);
      ev_r.timer_pin = 1'b0;
      step;
      rchk("pin second", `MPC_OFF_TIMER, 8'h01);
    end
    $display("timer test finished");
  endtask
  task automatic t_wdt;
    for (int r = 0; r < 3; r += 2)
    begin
      wr(`MPC_OFF_TIMER_CTRL, 8'h08 | r[2:0]);
      #1 wdt_n = 0;
      repeat (8)
      begin
        ev_r.wdt_osc_tick = 1'b1;
        step;
      end
      #1 check("wdt ticks", wdt_n[7:0], r ? 8'h02 : 8'h08);
    end
    $display("watchdog test finished");
  endtask
  task automatic t_gie;
    logic [3:0] seq [5] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'hA};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      core_in <= seq[i];
      @(posedge clk);
      core_in <= '0;
      #1 check("gie", global_irq_enable, (i == 0 || i == 2) ? 8'h01 : 8'h00);
    end
    $display("enable test finished");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_ctrl;
    t_conv;
    t_flags;
    t_timer;
    t_wdt;
    t_gie;
    test_done;
  end
  initial
  begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire

// ===== hw/mpc_conv_seq.sv
// conversion sequencer: busy from start until done, result capture on done
`timescale 1ns/1ns
`default_nettype none
module mpc_conv_seq (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       start,
  input  wire logic       conv_done_in,
  input  wire logic [7:0] conv_data_in,
  output logic            busy,
  output logic            done,
  output logic [7:0]      result
);
  mpc_pkg::mpc_conv_state_e st_r;

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= mpc_pkg::MPC_CONV_IDLE;
    else if (clk_en)
    begin
      unique case (st_r)
        mpc_pkg::MPC_CONV_IDLE: if (start) st_r <= mpc_pkg::MPC_CONV_BUSY;
        mpc_pkg::MPC_CONV_BUSY: if (conv_done_in) st_r <= mpc_pkg::MPC_CONV_IDLE;
        default: st_r <= mpc_pkg::MPC_CONV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      result <= 8'h00;
    else if (clk_en && st_r == mpc_pkg::MPC_CONV_BUSY && conv_done_in)
      result <= conv_data_in;
  end

  assign busy = (st_r == mpc_pkg::MPC_CONV_BUSY);
  assign done = clk_en && busy && conv_done_in;
endmodule
`default_nettype wire

// ===== hw/mpc_defs.svh
// register offsets, reset values, field positions and widths
`ifndef MPC_DEFS_SVH
`define MPC_DEFS_SVH
`define MPC_ADDR_W          5
`define MPC_OFF_TIMER       5'h01
`define MPC_OFF_CONV_CTRL   5'h09
`define MPC_OFF_CONV_RESULT 5'h0A
`define MPC_OFF_IRQ_STATUS  5'h0F
`define MPC_OFF_TIMER_CTRL  5'h10
`define MPC_OFF_PORT_A_DIR  5'h15
`define MPC_OFF_PORT_B_DIR  5'h16
`define MPC_OFF_AMP_GAIN    5'h19
`define MPC_OFF_IRQ_MASK    5'h1F
`define MPC_RST_CONV_CTRL   8'h00
`define MPC_RST_TIMER_CTRL  8'h00
`define MPC_RST_PORT_DIR    8'hFF
`define MPC_RST_AMP_GAIN    8'h00
`define MPC_RST_IRQ_MASK    8'h00
`define MPC_CC_SEG          5
`define MPC_CC_RUN          4
`define MPC_CC_PWR          3
`define MPC_TC_EDGE_IRQ     7
`define MPC_TC_GIE          6
`define MPC_TC_SRC          5
`define MPC_TC_CNT_EDGE     4
`define MPC_TC_ASSIGN       3
`define MPC_AG_AMP2_ON      7
`define MPC_AG_AMP1_ON      6
`define MPC_GAIN_MAX        3'h5
`define MPC_IF_CMP          6
`define MPC_IF_PULSE2       5
`define MPC_IF_PULSE1       4
`define MPC_IF_CONV         3
`define MPC_IF_EXT          2
`define MPC_IF_PORT         1
`define MPC_IF_TOVF         0
`define MPC_PRESC_W         8
`endif

// ===== hw/mpc_periph_bank.sv
// peripheral control and status register bank of the microcontroller core
//
// Operation
// - converter control bits 7 and 6 always read zero.
// - converter control bit 5 selects second (1) or first (0) control segment.
// - software writes run=1 to start; only completion clears it, writing 0 ignored.
// - power bit 1 runs converter; 0 switches off resistor reference.
// - channel_sel binary value picks analog input zero to seven.
// - channel_sel changes only while done flag and run are both low.
// - on completion load result, clear run, set done flag.
// - status bit 6 set on comparator output change, held until cleared.
// - status bits 5 and 4 set on pulse channel period, held until cleared.
// - status bit 3 set on conversion completion, held until cleared.
// - bit 2 set by external pin edge; bit 1 by second-port input change.
// - bit 0 set on timer overflow; bit 7 always reads zero.
// - status writes can only clear flags, never set them.
// - status read returns stored flags AND interrupt mask.
// - irq_edge_sel 0 selects rising, 1 falling external interrupt edge.
// - global enable set by enable/return instructions, cleared by disable or entry.
// - count_src_sel 0 instruction clock, 1 timer pin; pin as I/O needs 0.
// - count_edge_sel 0 counts rising, 1 falling pin transitions.
// - prescale_assign 0 gives prescaler to timer, 1 to watchdog.
// - ratio n divides timer by 2^(n+1), watchdog by 2^n.
// - direction bit 1 high impedance, 0 output; both registers read/write.
// - amplifier enable bits 7 and 6; disabled amplifier bypasses input.
// - three-bit gain field selects gain 2^code, 000 unity to 101 x32.
// - control bits 4 and 5 choose pin edges or instruction clock.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_defs.svh"
module mpc_periph_bank (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire mpc_pkg::mpc_bus_req_s bus_req,
  output logic [7:0]               bus_rdata,
  input  wire mpc_pkg::mpc_evt_s   evt_in,
  input  wire mpc_pkg::mpc_core_s  core_in,
  input  wire logic                conv_done_in,
  input  wire logic [7:0]          conv_data_in,
  output logic                     conv_start,
  output logic                     conv_power_on,
  output logic [2:0]               channel_sel,
  output logic                     ctrl_segment_sel,
  output logic                     global_irq_enable,
  output logic [6:0]               irq_pending,
  output logic [7:0]               port_a_direction,
  output logic [7:0]               port_b_direction,
  output logic                     amp1_on,
  output logic                     amp2_on,
  output logic [2:0]               amp1_gain,
  output logic [2:0]               amp2_gain,
  output logic                     wdt_tick
);
  logic [7:0] conv_ctrl_r;
  logic [7:0] timer_ctrl_r;
  logic [7:0] amp_gain_r;
  logic [7:0] irq_mask_r;
  logic [7:0] port_a_dir_r;
  logic [7:0] port_b_dir_r;
  logic [7:0] timer_r;
  logic [6:0] flags_r;
  logic [6:0] flags_set;
  logic [6:0] flags_clr;
  logic [6:0] flags_nxt;
  logic [7:0] rdata_nxt;
  logic       cmp_q_r;
  logic       ext_q_r;
  logic       tpin_q_r;
  logic [7:0] port_b_q_r;
  logic       evt_seen_r;
  logic       conv_busy;
  logic       conv_done;
  logic [7:0] conv_result;
  logic       run_req;
  logic       run_set;
  logic       ext_edge;
  logic       pin_edge;
  logic       timer_evt;
  logic       timer_tick;
  logic       timer_wr;
  logic       timer_ovf;
  logic       conv_wr;
  logic       status_wr;

  // true when a write strobe addresses the given register
  function automatic logic hit_wr(input mpc_pkg::mpc_bus_req_s r, input logic [4:0] off);
    hit_wr = r.wr && (r.addr == off);
  endfunction

  // codes beyond the top defined gain act as the top gain
  function automatic logic [2:0] gain_eff(input logic [2:0] code);
    gain_eff = (code > `MPC_GAIN_MAX) ? `MPC_GAIN_MAX : code;
  endfunction

  // edge of the selected polarity between the last and the present level
  function automatic logic edge_of(input logic prev, input logic now, input logic falling);
    edge_of = falling ? (prev && !now) : (!prev && now);
  endfunction

  // status as software and the core see it: stored flags gated by the mask
  function automatic logic [6:0] masked(input logic [6:0] f, input logic [7:0] m);
    masked = f & m[6:0];
  endfunction

  // previous pin levels for edge detection; inputs are synchronous to clk
  // clk_en low freezes the history too, so no edge is lost or doubled
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmp_q_r    <= 1'b0;
      ext_q_r    <= 1'b0;
      tpin_q_r   <= 1'b0;
      port_b_q_r <= 8'h00;
      evt_seen_r <= 1'b0;
    end
    else if (clk_en)
    begin
      cmp_q_r    <= evt_in.cmp_out;
      ext_q_r    <= evt_in.ext_pin;
      tpin_q_r   <= evt_in.timer_pin;
      port_b_q_r <= evt_in.port_b_in;
      evt_seen_r <= 1'b1;
    end
  end

  // first cycle after reset has no valid history, so no edges are reported
  assign ext_edge = evt_seen_r && edge_of(ext_q_r, evt_in.ext_pin,
                    timer_ctrl_r[`MPC_TC_EDGE_IRQ]);

  assign pin_edge = evt_seen_r && edge_of(tpin_q_r, evt_in.timer_pin,
                    timer_ctrl_r[`MPC_TC_CNT_EDGE]);

  // pin source assumes the timer pin is not in use as general I/O
  assign timer_evt = timer_ctrl_r[`MPC_TC_SRC] ? pin_edge : evt_in.instr_tick;

  // one prescaler serves the timer or the watchdog, never both at once
  mpc_prescale u_presc (
    .clk        (clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .timer_evt  (timer_evt),
    .wdt_evt    (evt_in.wdt_osc_tick),
    .to_wdt     (timer_ctrl_r[`MPC_TC_ASSIGN]),
    .ratio      (timer_ctrl_r[2:0]),
    .timer_tick (timer_tick),
    .wdt_tick   (wdt_tick)
  );

  // timer/counter; a software write wins over a count in the same cycle
  assign timer_wr = hit_wr(bus_req, `MPC_OFF_TIMER);

  always_ff @(posedge clk)
  begin
    if (reset)
      timer_r <= 8'h00;
    else if (clk_en)
    begin
      if (timer_wr)
        timer_r <= bus_req.wdata;
      else if (timer_tick)
        timer_r <= timer_r + 8'h01;
    end
  end

  // a write in the same cycle replaces the count, so it cannot overflow
  assign timer_ovf = timer_tick && !timer_wr && (timer_r == 8'hFF);

  // conversion start: only a 0-to-1 request while idle launches a conversion
  assign conv_wr = hit_wr(bus_req, `MPC_OFF_CONV_CTRL);
  assign run_req = conv_wr && bus_req.wdata[`MPC_CC_RUN];
  assign run_set = run_req && !conv_ctrl_r[`MPC_CC_RUN];
  // gated so that a frozen cycle launches nothing
  assign conv_start = clk_en && run_set;

  // the sequencer sees only a launching write, so a start while busy is dropped
  mpc_conv_seq u_conv (
    .clk          (clk),
    .reset        (reset),
    .clk_en       (clk_en),
    .start        (run_set),
    .conv_done_in (conv_done_in),
    .conv_data_in (conv_data_in),
    .busy         (conv_busy),
    .done         (conv_done),
    .result       (conv_result)
  );

  // converter control: segment and power plain; run set-only; channel gated
  always_ff @(posedge clk)
  begin
    if (reset)
      conv_ctrl_r <= `MPC_RST_CONV_CTRL;
    else if (clk_en)
    begin
      if (conv_wr)
      begin
        conv_ctrl_r[`MPC_CC_SEG] <= bus_req.wdata[`MPC_CC_SEG];
        conv_ctrl_r[`MPC_CC_PWR] <= bus_req.wdata[`MPC_CC_PWR];
        // channel held while a result is pending, so the two stay paired
        if (!flags_r[`MPC_IF_CONV] && !conv_ctrl_r[`MPC_CC_RUN])
          conv_ctrl_r[2:0] <= bus_req.wdata[2:0];
      end
      if (run_set)
        conv_ctrl_r[`MPC_CC_RUN] <= 1'b1;
      else if (conv_done)
        conv_ctrl_r[`MPC_CC_RUN] <= 1'b0;
      conv_ctrl_r[7:6] <= 2'b00;
    end
  end

  // the run bit mirrors the sequencer; both change on the same edges
  assign conv_power_on    = conv_ctrl_r[`MPC_CC_PWR];
  assign channel_sel      = conv_ctrl_r[2:0];
  assign ctrl_segment_sel = conv_ctrl_r[`MPC_CC_SEG];

  // timer / interrupt control; instruction events override a same-cycle write
  always_ff @(posedge clk)
  begin
    if (reset)
      timer_ctrl_r <= `MPC_RST_TIMER_CTRL;
    else if (clk_en)
    begin
      if (hit_wr(bus_req, `MPC_OFF_TIMER_CTRL))
        timer_ctrl_r <= bus_req.wdata;
      if (core_in.disable_irq_instr || core_in.irq_entry)
        timer_ctrl_r[`MPC_TC_GIE] <= 1'b0;
      else if (core_in.enable_irq_instr || core_in.return_from_irq_instr)
        timer_ctrl_r[`MPC_TC_GIE] <= 1'b1;
    end
  end

  // enable bit also reads back through the control register
  assign global_irq_enable = timer_ctrl_r[`MPC_TC_GIE];

  // plain read/write configuration registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      port_a_dir_r <= `MPC_RST_PORT_DIR;
      port_b_dir_r <= `MPC_RST_PORT_DIR;
    end
    else if (clk_en)
    begin
      if (hit_wr(bus_req, `MPC_OFF_PORT_A_DIR))
        port_a_dir_r <= bus_req.wdata;
      if (hit_wr(bus_req, `MPC_OFF_PORT_B_DIR))
        port_b_dir_r <= bus_req.wdata;
    end
  end

  // gain register keeps undefined codes; only the outputs clamp
  always_ff @(posedge clk)
  begin
    if (reset)
      amp_gain_r <= `MPC_RST_AMP_GAIN;
    else if (clk_en && hit_wr(bus_req, `MPC_OFF_AMP_GAIN))
      amp_gain_r <= bus_req.wdata;
  end

  // bit 7 of the mask is kept although no flag sits behind it
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_mask_r <= `MPC_RST_IRQ_MASK;
    else if (clk_en && hit_wr(bus_req, `MPC_OFF_IRQ_MASK))
      irq_mask_r <= bus_req.wdata;
  end

  // direction 1 = high impedance, 0 = driven
  assign port_a_direction = port_a_dir_r;
  assign port_b_direction = port_b_dir_r;

  // disabled amplifier bypasses its input, so the gain code is moot then
  assign amp2_on   = amp_gain_r[`MPC_AG_AMP2_ON];
  assign amp1_on   = amp_gain_r[`MPC_AG_AMP1_ON];
  assign amp2_gain = gain_eff(amp_gain_r[5:3]);
  assign amp1_gain = gain_eff(amp_gain_r[2:0]);

  // event flags
  always_comb
  begin
    flags_set = 7'h00;
    flags_set[`MPC_IF_CMP]    = evt_seen_r && (cmp_q_r != evt_in.cmp_out);
    flags_set[`MPC_IF_PULSE2] = evt_in.pulse2_hit;
    flags_set[`MPC_IF_PULSE1] = evt_in.pulse1_hit;
    flags_set[`MPC_IF_CONV]   = conv_done;
    flags_set[`MPC_IF_EXT]    = ext_edge;
    flags_set[`MPC_IF_PORT]   = evt_seen_r && (port_b_q_r != evt_in.port_b_in);
    flags_set[`MPC_IF_TOVF]   = timer_ovf;
  end

  // a zero in the written data clears that flag; a one leaves it alone
  assign status_wr = hit_wr(bus_req, `MPC_OFF_IRQ_STATUS);
  assign flags_clr = status_wr ? ~bus_req.wdata[6:0] : 7'h00;
  assign flags_nxt = (flags_r & ~flags_clr) | flags_set;

  // every flag is held until software clears it
  always_ff @(posedge clk)
  begin
    if (reset)
      flags_r <= 7'h00;
    else if (clk_en)
      flags_r <= flags_nxt;
  end

  // level seen by the core's interrupt logic
  assign irq_pending = masked(flags_r, irq_mask_r);

  // read mux; unmapped addresses return zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (bus_req.addr)
      `MPC_OFF_TIMER:       rdata_nxt = timer_r;
      `MPC_OFF_CONV_CTRL:   rdata_nxt = {2'b00, conv_ctrl_r[5:0]};
      // result register is read only; writes to it fall through
      `MPC_OFF_CONV_RESULT: rdata_nxt = conv_result;
      `MPC_OFF_IRQ_STATUS:  rdata_nxt = {1'b0, masked(flags_r, irq_mask_r)};
      `MPC_OFF_TIMER_CTRL:  rdata_nxt = timer_ctrl_r;
      `MPC_OFF_PORT_A_DIR:  rdata_nxt = port_a_dir_r;
      `MPC_OFF_PORT_B_DIR:  rdata_nxt = port_b_dir_r;
      `MPC_OFF_AMP_GAIN:    rdata_nxt = amp_gain_r;
      `MPC_OFF_IRQ_MASK:    rdata_nxt = irq_mask_r;
      default:              rdata_nxt = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      bus_rdata <= 8'h00;
    else if (clk_en)
      bus_rdata <= bus_req.rd ? rdata_nxt : 8'h00;
  end
endmodule
`default_nettype wire

// ===== hw/mpc_pkg.sv
// types shared by the peripheral control bank
package mpc_pkg;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mpc_bus_req_s;

  typedef struct packed {
    logic       cmp_out;
    logic       pulse1_hit;
    logic       pulse2_hit;
    logic       ext_pin;
    logic [7:0] port_b_in;
    logic       timer_pin;
    logic       instr_tick;
    logic       wdt_osc_tick;
  } mpc_evt_s;

  typedef struct packed {
    logic enable_irq_instr;
    logic return_from_irq_instr;
    logic disable_irq_instr;
    logic irq_entry;
  } mpc_core_s;

  typedef enum logic [1:0] {
    MPC_CONV_IDLE = 2'b01,
    MPC_CONV_BUSY = 2'b10
  } mpc_conv_state_e;
endpackage

// ===== hw/mpc_prescale.sv
// shared prescaler between timer/counter and watchdog
`timescale 1ns/1ns
`default_nettype none
`include "mpc_defs.svh"
module mpc_prescale (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       timer_evt,
  input  wire logic       wdt_evt,
  input  wire logic       to_wdt,
  input  wire logic [2:0] ratio,
  output var  logic       timer_tick,
  output var  logic       wdt_tick
);
  logic [`MPC_PRESC_W-1:0] cnt_r;
  logic                    evt;
  logic                    wrap;
  logic [3:0]              shift;

  // terminal count of a divide by 2^shift
  function automatic logic [`MPC_PRESC_W-1:0] term(input logic [3:0] s);
    term = (`MPC_PRESC_W)'((9'h001 << s) - 9'h001);
  endfunction

  assign shift = to_wdt ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1);
  assign evt   = to_wdt ? wdt_evt : timer_evt;
  assign wrap  = evt && (cnt_r >= term(shift));

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= '0;
    else if (clk_en && evt)
      cnt_r <= wrap ? '0 : cnt_r + 8'h01;
  end

  // whichever side loses the prescaler sees raw events
  assign timer_tick = to_wdt ? timer_evt : wrap;
  assign wdt_tick   = to_wdt ? wrap : wdt_evt;
endmodule
`default_nettype wire
